// file: src/ptf_target.sv
// Functional notes
// - paced, async fetch: one word per two clocks
// - paced, sync fetch: one word per three clocks
// - master not ready stretches fetch spacing
// - writes unaffected, one transfer each clock while the write buffer has room
// - paced reads pass without read buffer
// - busy at start gives retry, no data
// - backend silent too long: core asserts stopn
// - backend answer limit is eight clocks
// - busy held: every new cycle retried
`timescale 1ns/1ps
module ptf_target (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// pci side, decoded by the surrounding core
	input  wire logic        tgt_hit,
	input  wire logic        tgt_read,
	input  wire logic        framen,
	input  wire logic        irdyn,
	input  wire logic [31:0] ad_in,
	output logic      [31:0] ad_out,
	output logic             ad_oe,
	output logic             devseln_out,
	output logic             devseln_oe,
	output logic             trdyn_out,
	output logic             trdyn_oe,
	output logic             stopn_out,
	output logic             stopn_oe,
	// backend side
	input  wire logic        busy,
	output logic             data_phase_begin,
	output logic             dp_done,
	output logic             rd_stb_out,
	input  wire logic        rd_stb_in,
	input  wire logic [31:0] mem_data_in,
	output logic             wr_valid,
	input  wire logic        backend_write_accept,
	output logic      [31:0] mem_data_out
);

	ptf_pkg::ptf_state_e state_r;
	ptf_pkg::ptf_state_e state_nxt;
	ptf_pkg::ptf_ctrl_s  ctrl_r;
	ptf_pkg::ptf_stat_s  stat;
	logic        retry_seen_r;
	logic        timeout_seen_r;
	logic [15:0] xfer_cnt_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;
	logic        read_r;
	logic        word_valid_r;
	logic [31:0] ad_out_r;
	logic [1:0]  pace_cnt_r;
	logic [3:0]  wait_cnt_r;
	logic        dp_done_r;
	logic        in_data;
	logic        fetch;
	logic        xfer_rd;
	logic        xfer_wr;
	logic        xfer;
	logic        waiting;
	logic        timeout;
	logic        wbuf_in_ready;
	logic        wbuf_out_valid;
	logic        wr_setup;
	logic        wr_access;
	logic        rd_setup;
	logic        start_retry;
	logic        start_data;

	assign in_data     = (state_r == ptf_pkg::ST_DATA);
	assign start_retry = (state_r == ptf_pkg::ST_IDLE) && tgt_hit && busy;
	assign start_data  = (state_r == ptf_pkg::ST_IDLE) && tgt_hit && !busy;

	// apb decode; zero wait states, so pready is always high
	assign wr_access = psel && penable && pwrite;
	assign wr_setup  = wr_access;
	assign rd_setup  = psel && !penable && !pwrite;
	assign pready    = 1'b1;
	assign prdata    = prdata_r;
	assign pslverr   = pslverr_r;

	// read data and error answer are prepared in the setup cycle
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
		else if (psel && !penable)
		begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
			if (paddr == ptf_pkg::CTRL_OFS)
				prdata_r[1:0] <= ctrl_r;
			else if (paddr == ptf_pkg::STATUS_OFS)
				prdata_r[3:0] <= stat;
			else if (paddr == ptf_pkg::XFERCNT_OFS)
				prdata_r[15:0] <= xfer_cnt_r;
			else
				pslverr_r <= 1'b1;
			if (!rd_setup && !pwrite)
				pslverr_r <= 1'b1;
		end
	end

	// control register steers the fetch pacing
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			ctrl_r <= ptf_pkg::CTRL_RST;
		else if (wr_access && paddr == ptf_pkg::CTRL_OFS)
		begin
			ctrl_r.paced_en <= pwdata[ptf_pkg::CTRL_PACED_BIT];
			ctrl_r.rd_sync  <= pwdata[ptf_pkg::CTRL_RDSYNC_BIT];
		end
	end

	// sticky flags: a set in the clearing cycle wins
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			retry_seen_r   <= 1'b0;
			timeout_seen_r <= 1'b0;
		end
		else
		begin
			if (start_retry)
				retry_seen_r <= 1'b1;
			else if (wr_setup && paddr == ptf_pkg::STATUS_OFS
				&& pwdata[ptf_pkg::STAT_RETRY_BIT])
				retry_seen_r <= 1'b0;
			if (timeout)
				timeout_seen_r <= 1'b1;
			else if (wr_setup && paddr == ptf_pkg::STATUS_OFS
				&& pwdata[ptf_pkg::STAT_TIMEOUT_BIT])
				timeout_seen_r <= 1'b0;
		end
	end

	always_comb
	begin
		stat.retry_seen   = retry_seen_r;
		stat.timeout_seen = timeout_seen_r;
		stat.busy         = busy;
		stat.active       = !(state_r == ptf_pkg::ST_IDLE);
	end

	// data transfer counter, a write to XFERCNT_OFS clears it
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			xfer_cnt_r <= 16'h0000;
		else if (wr_access && paddr == ptf_pkg::XFERCNT_OFS)
			xfer_cnt_r <= 16'h0000;
		else if (xfer)
			xfer_cnt_r <= xfer_cnt_r + 16'h0001;
	end

	// bus handshakes
	assign xfer_rd = in_data && read_r && word_valid_r && !irdyn;
	assign xfer_wr = in_data && !read_r && wbuf_in_ready && !irdyn;
	assign xfer    = xfer_rd || xfer_wr;

	// fetch only when the pace counter has run out; with pacing off
	// the counter stays at zero and a new word is fetched in each clock that the held one is taken
	assign rd_stb_out = in_data && read_r && pace_cnt_r == 2'h0
		&& (!word_valid_r || xfer_rd);
	assign fetch = rd_stb_out && rd_stb_in;

	// backend waits: a pending fetch or an unaccepted write word
	assign waiting = in_data && ((read_r && rd_stb_out && !rd_stb_in)
		|| (!read_r && wbuf_out_valid && !backend_write_accept));
	assign timeout = waiting && wait_cnt_r == ptf_pkg::BE_WAIT_MAX;

	// direction is latched at the address phase
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			read_r <= 1'b0;
		else if (start_data)
			read_r <= tgt_read;
	end

	// single output word, no read buffer behind it
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			word_valid_r <= 1'b0;
			ad_out_r     <= 32'h0000_0000;
		end
		else if (!in_data)
			word_valid_r <= 1'b0;
		else if (fetch)
		begin
			word_valid_r <= 1'b1;
			ad_out_r     <= mem_data_in;
		end
		else if (xfer_rd)
			word_valid_r <= 1'b0;
	end

	// pace counter holds while the master is not ready
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			pace_cnt_r <= 2'h0;
		else if (!in_data)
			pace_cnt_r <= 2'h0;
		else if (fetch && ctrl_r.paced_en)
		begin
			if (ctrl_r.rd_sync)
				pace_cnt_r <= ptf_pkg::PACE_GAP_SYNC;
			else
				pace_cnt_r <= ptf_pkg::PACE_GAP_ASYNC;
		end
		else if (pace_cnt_r != 2'h0 && !irdyn)
			pace_cnt_r <= pace_cnt_r - 2'h1;
	end

	// backend answer timer, saturates at the limit
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			wait_cnt_r <= 4'h0;
		else if (start_data || !in_data)
			wait_cnt_r <= 4'h0;
		else if (fetch || (wr_valid && backend_write_accept))
			wait_cnt_r <= 4'h0;
		else if (waiting && wait_cnt_r != ptf_pkg::BE_WAIT_MAX)
			wait_cnt_r <= wait_cnt_r + 4'h1;
	end

	// target sequencer
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ptf_pkg::ST_IDLE:
				if (start_retry)
					state_nxt = ptf_pkg::ST_RETRY;
				else if (start_data)
					state_nxt = ptf_pkg::ST_DATA;
			ptf_pkg::ST_DATA:
				if (timeout)
					state_nxt = ptf_pkg::ST_STOP;
				else if (xfer && framen)
					state_nxt = ptf_pkg::ST_IDLE;
			ptf_pkg::ST_STOP,
			ptf_pkg::ST_RETRY:
				if (framen)
					state_nxt = ptf_pkg::ST_IDLE;
			default:
				state_nxt = ptf_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			state_r <= ptf_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// phase end pulse to the backend
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			dp_done_r <= 1'b0;
		else
			dp_done_r <= (state_r != ptf_pkg::ST_IDLE)
				&& (state_nxt == ptf_pkg::ST_IDLE);
	end
	// begin pulse is combinational so the first fetch is not delayed
	assign data_phase_begin = start_data;
	assign dp_done          = dp_done_r;

	// pci target signals; retry never drives trdyn low
	assign devseln_oe  = !(state_r == ptf_pkg::ST_IDLE);
	assign trdyn_oe    = devseln_oe;
	assign stopn_oe    = devseln_oe;
	assign devseln_out = !devseln_oe;
	assign trdyn_out   = !(in_data
		&& (read_r ? word_valid_r : wbuf_in_ready));
	assign stopn_out   = !(state_r == ptf_pkg::ST_STOP
		|| state_r == ptf_pkg::ST_RETRY);
	assign ad_out      = ad_out_r;
	assign ad_oe       = in_data && read_r;

	// write words queue here so the bus waits only when the buffer is full
	ptf_fifo #(
		.WIDTH (ptf_pkg::WBUF_WIDTH),
		.DEPTH (ptf_pkg::WBUF_DEPTH)
	) ptf_fifo_i (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.in_valid  (xfer_wr),
		.in_ready  (wbuf_in_ready),
		.in_data   (ad_in),
		.out_valid (wbuf_out_valid),
		.out_ready (backend_write_accept),
		.out_data  (mem_data_out)
	);
	assign wr_valid = wbuf_out_valid;

	// checks
	AST_PACE_ASYNC: assert property (@(posedge core_clk)
		disable iff (!resetn)
		fetch && ctrl_r.paced_en && !ctrl_r.rd_sync |=> !rd_stb_out)
		else $error("paced async fetch came too soon");

	AST_PACE_SYNC: assert property (@(posedge core_clk)
		disable iff (!resetn)
		fetch && ctrl_r.paced_en && ctrl_r.rd_sync
		|=> !rd_stb_out [*2])
		else $error("paced sync fetch came too soon");

	AST_IRDY_STRETCH: assert property (@(posedge core_clk)
		disable iff (!resetn)
		in_data && pace_cnt_r != 2'h0 && irdyn && !fetch
		|=> pace_cnt_r == $past(pace_cnt_r))
		else $error("pace spacing not stretched");

	// writes never fetch and wait only on a full buffer
	AST_WR_FULLRATE: assert property (@(posedge core_clk)
		disable iff (!resetn)
		in_data && !read_r && wbuf_in_ready
		|-> !trdyn_out && !rd_stb_out)
		else $error("write held off with room in buffer");

	// a word fetched on the last transfer is dropped with the cycle
	AST_RD_DIRECT: assert property (@(posedge core_clk)
		disable iff (!resetn)
		fetch && state_nxt == ptf_pkg::ST_DATA
		|=> ad_out == $past(mem_data_in) && !trdyn_out)
		else $error("fetched word not presented next clock");

	AST_BUSY_RETRY: assert property (@(posedge core_clk)
		disable iff (!resetn)
		start_retry |=> !stopn_out && trdyn_out && !devseln_out)
		else $error("busy at start did not retry");

	AST_TIMEOUT_STOP: assert property (@(posedge core_clk)
		disable iff (!resetn)
		in_data && waiting && wait_cnt_r == 4'h8
		|=> !stopn_out && trdyn_out)
		else $error("backend timeout did not stop");

	// the eighth waiting clock must not yet end the cycle
	AST_WAIT_LIMIT: assert property (@(posedge core_clk)
		disable iff (!resetn)
		in_data && waiting && wait_cnt_r == 4'h7 |=> stopn_out)
		else $error("stop came before eight clocks");

	AST_RETRY_NODATA: assert property (@(posedge core_clk)
		disable iff (!resetn)
		state_r == ptf_pkg::ST_RETRY
		|-> trdyn_out && !xfer && !rd_stb_out && wait_cnt_r == 4'h0)
		else $error("data moved in a retry");

	AST_TIMER_CLEAR: assert property (@(posedge core_clk)
		disable iff (!resetn)
		in_data && (fetch || (wr_valid && backend_write_accept))
		|=> wait_cnt_r == 4'h0)
		else $error("answer did not clear timer");

	COV_RETRY: cover property (@(posedge core_clk) start_retry);
	COV_TIMEOUT: cover property (@(posedge core_clk) timeout);
	COV_PACED_SYNC: cover property (@(posedge core_clk)
		fetch && ctrl_r.paced_en && ctrl_r.rd_sync ##3 fetch);
	COV_WBUF_FULL: cover property (@(posedge core_clk)
		in_data && !wbuf_in_ready);

endmodule

// file: src/ptf_pkg.sv
package ptf_pkg;

	// apb register map, byte addresses
	localparam logic [7:0] CTRL_OFS     = 8'h00;
	localparam logic [7:0] STATUS_OFS   = 8'h04;
	localparam logic [7:0] XFERCNT_OFS  = 8'h08;

	// control register fields
	localparam int CTRL_PACED_BIT  = 0;
	localparam int CTRL_RDSYNC_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;

	// status register fields, sticky ones clear on write of one
	localparam int STAT_RETRY_BIT   = 0;
	localparam int STAT_TIMEOUT_BIT = 1;
	localparam int STAT_BUSY_BIT    = 2;
	localparam int STAT_ACTIVE_BIT  = 3;

	// backend answer limit in clock cycles
	localparam int BE_WAIT_LIMIT = 8;
	localparam logic [3:0] BE_WAIT_MAX = 4'h8;

	// spacing between paced fetches, less the fetch cycle itself
	localparam logic [1:0] PACE_GAP_ASYNC = 2'h1;
	localparam logic [1:0] PACE_GAP_SYNC  = 2'h2;

	// write buffer shape
	localparam int WBUF_WIDTH = 32;
	localparam int WBUF_DEPTH = 8;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_DATA  = 4'h2,
		ST_STOP  = 4'h4,
		ST_RETRY = 4'h8
	} ptf_state_e;

	typedef struct packed {
		logic rd_sync;
		logic paced_en;
	} ptf_ctrl_s;

	typedef struct packed {
		logic active;
		logic busy;
		logic timeout_seen;
		logic retry_seen;
	} ptf_stat_s;

endpackage

// file: src/ptf_fifo.sv
`timescale 1ns/1ps
module ptf_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic             core_clk,
	input  wire logic             resetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      cnt_r;
	logic             push;
	logic             pop;

	// full and empty come straight from the fill count
	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_r[rd_ptr_r];

	// storage, no reset needed on the data words
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem_r[wr_ptr_r] <= in_data;
	end

	// pointers wrap because depth is a power of two
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r    <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + AW'(1);
			if (pop)
				rd_ptr_r <= rd_ptr_r + AW'(1);
			if (push && !pop)
				cnt_r <= cnt_r + (AW+1)'(1);
			else if (pop && !push)
				cnt_r <= cnt_r - (AW+1)'(1);
		end
	end

endmodule

// file: test/ptf_pci_master.sv
`timescale 1ns/1ps
// pci master model: one target cycle per call, words counted on trdyn
module ptf_pci_master (
	input  wire logic        core_clk,
	input  wire logic        trdyn_out,
	input  wire logic        stopn_out,
	output logic             tgt_hit,
	output logic             tgt_read,
	output logic             framen,
	output logic             irdyn,
	output logic      [31:0] ad_in
);
	// idle bus: frame and ready released high
	initial
	begin
		{tgt_hit, tgt_read} = 2'h0;
		{framen, irdyn} = 2'h3;
		ad_in = 32'h0;
	end
	// stall keeps irdyn off that many clocks after each word except the last two
	task automatic run(input logic rd, input int n, input int stall,
		input logic [31:0] base, output int got);
		int sc;
		logic xf;
		got = 0;
		sc = 0;
		tgt_hit <= 1'b1;
		tgt_read <= rd;
		framen <= 1'b0;
		irdyn <= 1'b0;
		ad_in <= base;
		repeat (80)
		begin
			@(posedge core_clk);
			tgt_hit <= 1'b0;
			xf = !irdyn && !trdyn_out;
			got += int'(xf);
			// last phase ends on a word or a stop; data then not held
			if (framen && (xf || !stopn_out))
			begin
				irdyn <= 1'b1;
				ad_in <= ~ad_in;
				return;
			end
			if (xf)
				ad_in <= ad_in + 32'h1;
			// frame may only rise while irdyn is asserted
			if (!stopn_out)
			begin
				framen <= 1'b1;
				irdyn <= 1'b0;
			end
			else if (xf && got == n - 1)
				framen <= 1'b1;
			else if (xf && stall > 0)
			begin
				irdyn <= 1'b1;
				sc = stall;
			end
			else if (irdyn)
			begin
				sc--;
				irdyn <= (sc > 0) ? 1'b1 : 1'b0;
			end
		end
		got = -1;
	endtask
endmodule

// file: test/pci_target_backend_flow_control_tb_top.sv
`timescale 1ns/1ps
module pci_target_backend_flow_control_tb_top;
	logic        core_clk, pready, pslverr, tgt_hit, tgt_read, framen, irdyn;
	logic        resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        busy = 1'b0, rd_stb_in = 1'b1, backend_write_accept = 1'b0;
	logic        ad_oe, devseln_out, devseln_oe, trdyn_out, trdyn_oe;
	logic        stopn_out, stopn_oe, data_phase_begin, dp_done, err_v;
	logic        rd_stb_out, wr_valid;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, mem_data_in = 32'hA0000000;
	logic [31:0] prdata, ad_in, ad_out, mem_data_out, rd_v, exp_rd, exp_wr;
	int          n_errors = 0, cmp_count = 0, cyc = 0;
	int          last_f, nf, gmin, gmax, t_rd, t_stop, dpb_n, n_wr, wfirst;
	int          wlast, pops, got, m, dpd_n;
	logic [1:0]  cfg [3] = '{2'h0, 2'h3, 2'h1};
	int          gap [3] = '{1, 3, 2};
	ptf_target ptf_target_i (
		.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .tgt_hit, .tgt_read, .framen, .irdyn,
		.ad_in, .ad_out, .ad_oe, .devseln_out, .devseln_oe, .trdyn_out,
		.trdyn_oe, .stopn_out, .stopn_oe, .busy, .data_phase_begin,
		.dp_done, .rd_stb_out, .rd_stb_in, .mem_data_in, .wr_valid,
		.backend_write_accept, .mem_data_out
	);
	ptf_pci_master ptf_pci_master_i (
		.core_clk, .trdyn_out, .stopn_out, .tgt_hit, .tgt_read, .framen,
		.irdyn, .ad_in
	);
	initial
		core_clk = 1'b0;
	// 20 MHz
	always
		#25 core_clk = ~core_clk;
	task automatic check(input logic ok, input string msg);
		cmp_count++;
		if (!ok)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	task automatic tally_and_finish();
		if (n_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// apb master: setup, then access until pready
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		repeat (20)
		begin
			@(posedge core_clk);
			if (pready === 1'b1)
			begin
				rd_v = prdata;
				err_v = pslverr;
				psel <= 1'b0;
				penable <= 1'b0;
				return;
			end
		end
		check(1'b0, "bus wait timed out");
		tally_and_finish();
	endtask
	// one target cycle; statistics restart off the clock edge
	task automatic pci(input logic rd, input int n, input int st,
		input logic [31:0] b);
		@(negedge core_clk);
		{nf, gmax, n_wr, pops, dpb_n, dpd_n} = 0;
		{t_rd, t_stop} = '1;
		gmin = 99;
		exp_rd = mem_data_in;
		exp_wr = b;
		@(posedge core_clk);
		ptf_pci_master_i.run(rd, n, st, b, got);
		check(got >= 0, "target cycle hung");
		repeat (3)
			@(posedge core_clk);
		@(negedge core_clk);
		check(dpd_n == 1, "phase end pulse");
	endtask
	// backend accepts again and empties the write buffer
	task automatic drain(input int n);
		@(posedge core_clk);
		backend_write_accept <= 1'b1;
		repeat (40)
		begin
			@(posedge core_clk);
			if (wr_valid === 1'b0)
				break;
		end
		backend_write_accept <= 1'b0;
		@(negedge core_clk);
		check(pops == n && wr_valid === 1'b0, "buffer drain");
	endtask
	// backend word source and bus watcher
	always @(posedge core_clk)
	begin
		cyc++;
		if (rd_stb_out && rd_stb_in)
		begin
			if (nf > 0 && cyc - last_f < gmin)
				gmin = cyc - last_f;
			if (nf > 0 && cyc - last_f > gmax)
				gmax = cyc - last_f;
			nf++;
			last_f = cyc;
			mem_data_in <= mem_data_in + 32'h1;
		end
		if (trdyn_oe && !trdyn_out && !irdyn && tgt_read)
		begin
			check(ad_out === exp_rd, "read word order");
			exp_rd++;
		end
		if (trdyn_oe && !trdyn_out && !irdyn && !tgt_read)
		begin
			wfirst = (n_wr == 0) ? cyc : wfirst;
			wlast = cyc;
			n_wr++;
		end
		if (wr_valid && backend_write_accept)
		begin
			check(mem_data_out === exp_wr, "write word order");
			exp_wr++;
			pops++;
		end
		if (stopn_oe && !stopn_out && t_stop < 0)
			t_stop = cyc;
		if (rd_stb_out && t_rd < 0)
			t_rd = cyc;
		if (data_phase_begin)
			dpb_n++;
		if (dp_done)
			dpd_n++;
		// target claims the bus and drives data only on reads
		if (trdyn_oe && !trdyn_out && !irdyn)
			check(devseln_out === 1'b0 && ad_oe === tgt_read, "target drive");
	end
	// hang guard
	initial
	begin
		repeat (20000)
			@(posedge core_clk);
		check(1'b0, "run timed out");
		tally_and_finish();
	end
	initial
	begin
		repeat (6)
			@(posedge core_clk);
		check(stopn_oe === 1'b0 && wr_valid === 1'b0 && prdata === 32'h0,
			"reset state");
		resetn <= 1'b1;
		apb(1'b1, 8'h0C, 32'hFFFFFFFF);
		check(err_v === 1'b1 && rd_v === 32'h0, "unmapped access");
		apb(1'b0, ptf_pkg::CTRL_OFS, 32'h0);
		check(rd_v === {30'h0, ptf_pkg::CTRL_RST}, "control reset");
		// unpaced, paced sync, paced async
		for (m = 0; m < 3; m++)
		begin
			apb(1'b1, ptf_pkg::CTRL_OFS, {30'h0, cfg[m]});
			apb(1'b0, ptf_pkg::CTRL_OFS, 32'h0);
			check(rd_v === {30'h0, cfg[m]}, "control readback");
			pci(1'b1, 10, 0, 32'h0);
			check(got == 10 && dpb_n == 1 && gmin == gap[m] && gmax == gap[m]
				&& t_stop < 0, "fetch spacing");
		end
		pci(1'b1, 6, 2, 32'h0);
		check(got == 6 && gmin >= 2 && gmax > 2, "stall stretch");
		pci(1'b0, 5, 0, 32'hB0000000);
		check(n_wr == 5 && wlast - wfirst == 4, "write rate");
		drain(5);
		// accept withheld: buffer fills, then the core gives up
		pci(1'b0, 12, 0, 32'hC0000000);
		check(got == 8 && t_stop >= 0, "buffer full stop");
		drain(8);
		@(posedge core_clk);
		busy <= 1'b1;
		repeat (2)
		begin
			pci(1'b1, 2, 0, 32'h0);
			check(got == 0 && t_stop >= 0 && dpb_n == 0
				&& t_rd < 0, "busy retry");
		end
		apb(1'b0, ptf_pkg::STATUS_OFS, 32'h0);
		check(rd_v[2:0] === 3'h7, "busy status");
		busy <= 1'b0;
		apb(1'b1, ptf_pkg::STATUS_OFS, 32'h3);
		apb(1'b0, ptf_pkg::STATUS_OFS, 32'h0);
		check(rd_v[2:0] === 3'h0, "status clear");
		@(posedge core_clk);
		rd_stb_in <= 1'b0;
		pci(1'b1, 2, 0, 32'h0);
		check(got == 0 && t_stop - t_rd == 9, "timeout");
		apb(1'b0, ptf_pkg::STATUS_OFS, 32'h0);
		check(rd_v[1:0] === 2'h2, "timeout status");
		// 30 + 6 read words, 5 + 8 write words, none in retries
		apb(1'b0, ptf_pkg::XFERCNT_OFS, 32'h0);
		check(rd_v === 32'h31, "transfer count");
		apb(1'b1, ptf_pkg::XFERCNT_OFS, 32'h0);
		apb(1'b0, ptf_pkg::XFERCNT_OFS, 32'h0);
		check(rd_v === 32'h0, "transfer count clear");
		tally_and_finish();
	end
endmodule
